// [shared/scirq_pkg.sv]
package scirq_pkg;

   // Number of sockets
   localparam int NUM_SOCK = 2;

   // Register address decode
   localparam logic [11:0] MEM_SPACE_BASE = 12'h800;   // socket memory space block
   localparam logic [7:0]  OFS_FLAGS      = 8'h04;     // status-change flag register
   localparam logic [7:0]  OFS_IRQ_CFG    = 8'h05;     // status_change_irq_config
   localparam logic [7:0]  OFS_WIN_EN     = 8'h06;     // address_window_enable
   localparam logic [7:0]  LEGACY_SOCK_B  = 8'h40;     // socket B legacy offset step

   // Reset values
   localparam logic [7:0]  IRQ_CFG_RESET  = 8'h00;
   localparam logic [7:0]  WIN_EN_RESET   = 8'h00;
   localparam logic [3:0]  FLAGS_RESET    = 4'h0;
   localparam logic        DETECT_HIST_RESET = 1'h1;  // Detect lines idle high
   localparam logic        READY_HIST_RESET  = 1'h0;  // Ready line idle low

   // Field positions, status_change_irq_config
   localparam int CFG_SEL_MSB        = 7;
   localparam int CFG_SEL_LSB        = 4;
   localparam int CFG_CARD_DETECT    = 3;
   localparam int CFG_READY_RISE     = 2;
   localparam int CFG_BATT_WARN      = 1;
   localparam int CFG_BATT_DEAD      = 0;

   // Field positions, address_window_enable
   localparam int WIN_IO1            = 7;
   localparam int WIN_IO0            = 6;
   localparam int WIN_RSVD           = 5;
   localparam logic [7:0] WIN_WMASK  = 8'hDF;          // bit 5 not writable

   // Status-change select codes
   localparam logic [3:0] SEL_NO_ISA = 4'h0;
   localparam logic [3:0] SEL_SMI    = 4'h2;

   // Register selected by an access
   typedef enum logic [1:0] {
      SCIRQ_SEL_NONE,
      SCIRQ_SEL_FLAGS,
      SCIRQ_SEL_CFG,
      SCIRQ_SEL_WIN
   } scirq_sel_t;

endpackage

// [rtl/scirq_top.sv]
`timescale 1ns/1ps
module scirq_top
   import scirq_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  reg_space,
   input  wire logic                  reg_sock,
   input  wire logic [11:0]           reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata_q,
   output logic                       reg_rvalid_q,
   input  wire logic                  diag_status_change_pci_route,
   input  wire logic [NUM_SOCK-1:0]   status_change_pci_route,
   input  wire logic [NUM_SOCK-1:0]   flag_clear_by_write,
   input  wire logic [NUM_SOCK-1:0]   card_detect_line_1_b,
   input  wire logic [NUM_SOCK-1:0]   card_detect_line_2_b,
   input  wire logic [NUM_SOCK-1:0]   card_ready,
   input  wire logic [NUM_SOCK-1:0]   battery_warning,
   input  wire logic [NUM_SOCK-1:0]   card_status_change_pin,
   input  wire logic [NUM_SOCK-1:0][7:0] win_hit,
   output logic      [NUM_SOCK-1:0][7:0] win_ack_q,
   output logic      [NUM_SOCK-1:0][7:0] win_enable_q,
   output logic      [15:0]           isa_irq_q,
   output logic                       system_management_interrupt_q,
   output logic                       pci_int_q
);

   // Decode of one access: socket and register
   function automatic scirq_sel_t dec_sel(input logic space, input logic [11:0] addr);
      logic [7:0] low;
      dec_sel = SCIRQ_SEL_NONE;
      low     = addr[7:0];
      if (space) begin
         if (addr[11:8] != MEM_SPACE_BASE[11:8]) begin
            low = 8'hFF;
         end
      end else begin
         if (addr[11:8] != 4'h0) begin
            low = 8'hFF;
         end else begin
            low = addr[7:0] & ~LEGACY_SOCK_B;
         end
      end
      if (low == OFS_FLAGS) begin
         dec_sel = SCIRQ_SEL_FLAGS;
      end else if (low == OFS_IRQ_CFG) begin
         dec_sel = SCIRQ_SEL_CFG;
      end else if (low == OFS_WIN_EN) begin
         dec_sel = SCIRQ_SEL_WIN;
      end
   endfunction

   function automatic logic dec_sock(input logic space, input logic sock, input logic [11:0] addr);
      dec_sock = space ? sock : ((addr[7:0] & LEGACY_SOCK_B) != 8'h00);
   endfunction

   scirq_sel_t                    acc_sel;
   logic                          acc_sock;
   logic [NUM_SOCK-1:0][7:0]      cfg_v;
   logic [NUM_SOCK-1:0][7:0]      win_v;
   logic [NUM_SOCK-1:0][3:0]      flag_v;
   logic [NUM_SOCK-1:0][15:0]     isa_v;
   logic [NUM_SOCK-1:0]           smi_v;
   logic [NUM_SOCK-1:0]           pci_v;

   // Access decode shared by all sockets
   // config register offsets
   always_comb begin
      acc_sel  = dec_sel(reg_space, reg_addr);
      acc_sock = dec_sock(reg_space, reg_sock, reg_addr);
   end

   for (genvar s = 0; s < NUM_SOCK; s++) begin : g_sock
      logic [7:0]  cfg_q;
      logic [7:0]  cfg_d;
      logic [7:0]  win_q;
      logic [7:0]  win_d;
      logic [3:0]  flag_q;
      logic [3:0]  flag_d;
      logic        cd1_q;
      logic        cd1_d;
      logic        cd2_q;
      logic        cd2_d;
      logic        rdy_q;
      logic        rdy_d;
      logic [3:0]  ev;
      logic [3:0]  en;
      logic [3:0]  clr;
      logic        hit;
      logic        pend;
      logic [3:0]  sel;
      logic [15:0] isa_l;
      logic        smi_l;
      logic        pci_l;

      // Next values of this socket's two registers
      always_comb begin
         hit   = (acc_sock == 1'(s));
         cfg_d = cfg_q;
         win_d = win_q;
         if (reg_wr && hit && acc_sel == SCIRQ_SEL_CFG) begin
            cfg_d = reg_wdata;
         end
         if (reg_wr && hit && acc_sel == SCIRQ_SEL_WIN) begin
            win_d = reg_wdata & WIN_WMASK;
         end
      end

      // Socket configuration registers
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            cfg_q <= IRQ_CFG_RESET;
            win_q <= WIN_EN_RESET;
         end else begin
            cfg_q <= cfg_d;
            win_q <= win_d;
         end
      end

      // Pin history for the edge detectors
      always_comb begin
         cd1_d = card_detect_line_1_b[s];
         cd2_d = card_detect_line_2_b[s];
         rdy_d = card_ready[s];
      end

      // History starts at idle pin levels, so no false edge
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            cd1_q <= DETECT_HIST_RESET;
            cd2_q <= DETECT_HIST_RESET;
            rdy_q <= READY_HIST_RESET;
         end else begin
            cd1_q <= cd1_d;
            cd2_q <= cd2_d;
            rdy_q <= rdy_d;
         end
      end

      // Status-change flags, set wins over clear
      always_comb begin
         ev[3] = (card_detect_line_1_b[s] ^ cd1_q) | (card_detect_line_2_b[s] ^ cd2_q);
         ev[2] = card_ready[s] & ~rdy_q;
         ev[1] = battery_warning[s];
         ev[0] = card_status_change_pin[s];
         en    = {cfg_q[CFG_CARD_DETECT], cfg_q[CFG_READY_RISE],
                  cfg_q[CFG_BATT_WARN], cfg_q[CFG_BATT_DEAD]};
         clr = 4'h0;
         if (hit && acc_sel == SCIRQ_SEL_FLAGS) begin
            if (flag_clear_by_write[s]) begin
               clr = reg_wr ? reg_wdata[3:0] : 4'h0;
            end else begin
               clr = reg_rd ? 4'hF : 4'h0;
            end
         end
         flag_d = ((flag_q & ~clr) | (ev & en)) & en;
      end

      // Status-change flag register
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            flag_q <= FLAGS_RESET;
         end else begin
            flag_q <= flag_d;
         end
      end

      // Interrupt routing for this socket
      always_comb begin
         pend  = |flag_q;
         sel   = cfg_q[CFG_SEL_MSB:CFG_SEL_LSB];
         isa_l = 16'h0000;
         smi_l = 1'h0;
         pci_l = pend & (status_change_pci_route[s] |
                         (sel == SEL_NO_ISA && diag_status_change_pci_route));
         // code 0000 drives no ISA line
         // code to IRQ line or SYSTEM_MANAGEMENT_INTERRUPT
         if (!status_change_pci_route[s] && sel != SEL_NO_ISA) begin
            if (sel == SEL_SMI) begin
               smi_l = pend;
            end else begin
               isa_l[sel] = pend;
            end
         end
      end

      // Hand this socket's state to the shared logic
      assign cfg_v[s]  = cfg_q;
      assign win_v[s]  = win_q;
      assign flag_v[s] = flag_q;
      assign isa_v[s]  = isa_l;
      assign smi_v[s]  = smi_l;
      assign pci_v[s]  = pci_l;
   end

   logic [7:0]               rdata_d;
   logic                     rvalid_d;
   logic [NUM_SOCK-1:0][7:0] ack_d;
   logic [NUM_SOCK-1:0][7:0] wen_d;
   logic [15:0]              isa_d;
   logic                     smi_d;
   logic                     pci_d;

   // Read-back data for the addressed socket
   always_comb begin
      rvalid_d = reg_rd;
      rdata_d  = 8'h00;
      if (reg_rd) begin
         if (acc_sel == SCIRQ_SEL_FLAGS) begin
            rdata_d = {4'h0, flag_v[acc_sock]};
         end else if (acc_sel == SCIRQ_SEL_CFG) begin
            rdata_d = cfg_v[acc_sock];
         end else if (acc_sel == SCIRQ_SEL_WIN) begin
            rdata_d = win_v[acc_sock];
         end
      end
   end

   // Read-back registers, zero when no read is answered
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q  <= 8'h00;
         reg_rvalid_q <= 1'h0;
      end else begin
         reg_rdata_q  <= rdata_d;
         reg_rvalid_q <= rvalid_d;
      end
   end

   // Window acknowledge, gated by each enable bit
   always_comb begin
      for (int i = 0; i < NUM_SOCK; i++) begin
         ack_d[i] = win_hit[i] & win_v[i];
         wen_d[i] = win_v[i];
      end
   end

   // Window acknowledge and enable copies
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         win_ack_q    <= '0;
         win_enable_q <= '0;
      end else begin
         win_ack_q    <= ack_d;
         win_enable_q <= wen_d;
      end
   end

   // Interrupt lines shared by both sockets
   always_comb begin
      isa_d = 16'h0000;
      smi_d = 1'h0;
      pci_d = 1'h0;
      for (int i = 0; i < NUM_SOCK; i++) begin
         isa_d = isa_d | isa_v[i];
         smi_d = smi_d | smi_v[i];
         pci_d = pci_d | pci_v[i];
      end
   end

   // Interrupt output registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         isa_irq_q                     <= 16'h0000;
         system_management_interrupt_q <= 1'h0;
         pci_int_q                     <= 1'h0;
      end else begin
         isa_irq_q                     <= isa_d;
         system_management_interrupt_q <= smi_d;
         pci_int_q                     <= pci_d;
      end
   end

endmodule

// [tb/scirq_sva.sv]
`timescale 1ns/1ps
module scirq_sva
   import scirq_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     rst_b,
   input wire logic                     reg_rd,
   input wire logic [11:0]              reg_addr,
   input wire logic [7:0]               reg_rdata_q,
   input wire logic                     reg_rvalid_q,
   input wire logic [NUM_SOCK-1:0]      status_change_pci_route,
   input wire logic [NUM_SOCK-1:0][7:0] win_hit,
   input wire logic [NUM_SOCK-1:0][7:0] win_ack_q,
   input wire logic [NUM_SOCK-1:0][7:0] win_enable_q,
   input wire logic [15:0]              isa_irq_q,
   input wire logic                     system_management_interrupt_q,
   input wire logic                     pci_int_q
);
   // One clock domain, async reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   chk_read_answer: assert property (reg_rd |=> reg_rvalid_q)
      else $error("read not answered");
   chk_rdata_idle: assert property (!reg_rvalid_q |-> reg_rdata_q == 8'h00)
      else $error("read data not zero when idle");
   chk_win_ack: assert property (win_ack_q == ($past(win_hit) & win_enable_q))
      else $error("window ack mismatch");
   chk_rsvd_read: assert property
      (reg_rvalid_q && ($past(reg_addr) & 12'h00F) == 12'h006 |-> !reg_rdata_q[WIN_RSVD])
      else $error("reserved window bit read as one");
   chk_flag_upper: assert property
      (reg_rvalid_q && ($past(reg_addr) & 12'h00F) == 12'h004 |-> reg_rdata_q[7:4] == 4'h0)
      else $error("flag upper bits not zero");
   chk_isa_unused: assert property (isa_irq_q[0] == 1'b0 && isa_irq_q[2] == 1'b0)
      else $error("unused legacy line driven");
   chk_route_pci: assert property (status_change_pci_route == 2'h3 &&
      $past(status_change_pci_route) == 2'h3 && $past(status_change_pci_route, 2) == 2'h3
      |-> isa_irq_q == 16'h0000 && !system_management_interrupt_q)
      else $error("legacy line driven while routed to pci");
   chk_reset_clear: assert property ($rose(rst_b) |-> win_enable_q == '0 && !pci_int_q)
      else $error("outputs not clear after reset");
   chk_win_rsvd: assert property (!win_enable_q[0][WIN_RSVD] && !win_enable_q[1][WIN_RSVD])
      else $error("reserved window enable bit set");
endmodule

// [tb/scirq_card_model.sv]
`timescale 1ns/1ps
module scirq_card_model (
   input  wire logic  clk,
   output logic [1:0] detect_b,
   output logic [1:0] ready,
   output logic [1:0] warn,
   output logic [1:0] status
);
   // No card seated (detect lines high), no events pending
   initial begin
      detect_b = 2'h3;
      ready = 2'h0;
      warn = 2'h0;
      status = 2'h0;
   end
   // Change one card line just after an edge
   task automatic drive(input int which, input int s, input logic v);
      @(posedge clk);
      #1;
      case (which)
         0: detect_b[s] = v;
         1: ready[s] = v;
         2: warn[s] = v;
         default: status[s] = v;
      endcase
   endtask
endmodule

// [tb/socket_irq_and_window_enable_test.sv]
`timescale 1ns/1ps
module socket_irq_and_window_enable_test
   import scirq_pkg::*;
;
   logic                     clk = 1'b0, rst_b = 1'b0, sp = 1'b0, sk = 1'b0, wr = 1'b0, rd = 1'b0;
   logic                     diag = 1'b0, rvalid, system_management_interrupt, pci;
   logic [11:0]              addr = 12'h000;
   logic [7:0]               wdata = 8'h00, rdata;
   logic [1:0]               route = 2'h0, clr_wr = 2'h0, det_b, rdy, warn, stat;
   logic [NUM_SOCK-1:0][7:0] hit = '0, ack, wen;
   logic [15:0]              isa;
   int                       error_cnt = 0, n_compared = 0;
   scirq_top dut_u (.clk(clk), .rst_b(rst_b), .reg_space(sp), .reg_sock(sk), .reg_addr(addr), .reg_wr(wr),
      .reg_rd(rd), .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
      .diag_status_change_pci_route(diag), .status_change_pci_route(route), .flag_clear_by_write(clr_wr),
      .card_detect_line_1_b(det_b), .card_detect_line_2_b(det_b), .card_ready(rdy), .battery_warning(warn),
      .card_status_change_pin(stat), .win_hit(hit), .win_ack_q(ack), .win_enable_q(wen), .isa_irq_q(isa),
      .system_management_interrupt_q(system_management_interrupt), .pci_int_q(pci));
   scirq_card_model card_u (.clk(clk), .detect_b(det_b), .ready(rdy), .warn(warn), .status(stat));
   // Clock and watchdog
   always #2 clk = ~clk;
   initial begin
      #20000;
      error_cnt++;
      wrap_up();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // One register cycle, strobe for one edge
   task automatic acc(input logic w, input logic s, input logic m, input logic [7:0] r, input logic [7:0] d);
      @(posedge clk);
      #1;
      sk = s;
      sp = m;
      addr = m ? (MEM_SPACE_BASE | {4'h0, r}) : {4'h0, (s ? LEGACY_SOCK_B : 8'h00) | r};
      wdata = d;
      wr = w;
      rd = !w;
      @(posedge clk);
      #1;
      wr = 1'b0;
      rd = 1'b0;
   endtask
   task automatic rdc(input logic s, input logic m, input logic [7:0] r, input logic [7:0] exp);
      acc(1'b0, s, m, r, 8'h00);
      chk({7'h00, rvalid, rdata}, {8'h01, exp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      wt(10);
      rst_b = 1'b1;
      for (int i = 0; i < 12; i++) rdc(i[0], i[1], 8'h04 + 8'(i / 4), 8'h00);
      acc(1'b1, 1'b0, 1'b0, 8'h07, 8'hFF);
      rdc(1'b0, 1'b0, 8'h07, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_IRQ_CFG, 8'hF8);
      rdc(1'b0, 1'b1, OFS_IRQ_CFG, 8'hF8);
      rdc(1'b1, 1'b0, OFS_IRQ_CFG, 8'h00);
      acc(1'b1, 1'b1, 1'b1, OFS_WIN_EN, 8'hFF);
      rdc(1'b1, 1'b0, OFS_WIN_EN, 8'hDF);
      hit = '1;
      wt(3);
      chk({ack[1], ack[0]}, 16'hDF00);
      chk({wen[1], wen[0]}, 16'hDF00);
      card_u.drive(0, 0, 1'b0);
      wt(4);
      chk(isa, 16'h8000);
      rdc(1'b0, 1'b0, OFS_FLAGS, 8'h08);
      wt(3);
      chk(isa, 16'h0000);
      card_u.drive(2, 0, 1'b1);
      for (int c = 0; c < 16; c++) begin
         acc(1'b1, 1'b0, 1'b0, OFS_IRQ_CFG, {c[3:0], 4'h2});
         wt(3);
         chk(isa, (c == 0 || c == 2) ? 16'h0000 : 16'h0001 << c);
         chk({system_management_interrupt, pci}, {c == 2, 1'b0});
      end
      diag = 1'b1;
      acc(1'b1, 1'b0, 1'b0, OFS_IRQ_CFG, 8'h02);
      wt(3);
      chk({isa, system_management_interrupt, pci}, 18'h00001);
      diag = 1'b0;
      route = 2'h3;
      acc(1'b1, 1'b0, 1'b0, OFS_IRQ_CFG, 8'h32);
      wt(3);
      chk({isa, system_management_interrupt, pci}, 18'h00001);
      route = 2'h0;
      acc(1'b1, 1'b0, 1'b0, OFS_IRQ_CFG, 8'h30);
      wt(3);
      chk(isa, 16'h0000);
      rdc(1'b0, 1'b0, OFS_FLAGS, 8'h00);
      clr_wr = 2'h1;
      acc(1'b1, 1'b0, 1'b0, OFS_IRQ_CFG, 8'h14);
      card_u.drive(1, 0, 1'b1);
      wt(4);
      chk(isa, 16'h0002);
      rdc(1'b0, 1'b0, OFS_FLAGS, 8'h04);
      rdc(1'b0, 1'b0, OFS_FLAGS, 8'h04);
      acc(1'b1, 1'b0, 1'b0, OFS_FLAGS, 8'h04);
      wt(3);
      chk(isa, 16'h0000);
      acc(1'b1, 1'b1, 1'b0, OFS_IRQ_CFG, 8'hA1);
      card_u.drive(3, 1, 1'b1);
      wt(4);
      chk(isa, 16'h0400);
      wrap_up();
   end
endmodule
bind scirq_top scirq_sva chk_u (.clk(clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .status_change_pci_route(status_change_pci_route),
   .win_hit(win_hit), .win_ack_q(win_ack_q), .win_enable_q(win_enable_q), .isa_irq_q(isa_irq_q),
   .system_management_interrupt_q(system_management_interrupt_q), .pci_int_q(pci_int_q));
